// [test/sd_card_model.sv]
// card side model: stopping link clock, pulled-up command line, interrupt pin
`timescale 1ns/100ps
module sd_card_model (
  input wire logic clkRun,
  input wire logic conflict,
  input wire logic irqReq,
  output logic cardClk,
  output logic cmdLine,
  output logic irqN,
  output int edgeCnt
);
  // ----------
  // card pins
  // ----------
  initial cardClk = 1'h0;
  initial edgeCnt = 0;
  // clock stands low outside frames
  always #160 cardClk = clkRun ? ~cardClk : 1'h0;
  always @(posedge cardClk) edgeCnt++;
  // card pulls the line low, pull-up otherwise
  assign cmdLine = ~conflict;
  // interrupt held until the card source is cleared
  assign irqN = ~irqReq;
endmodule : sd_card_model

// [test/test_sd_gate_status.sv]
// self-checking bench for the sd clock gating and status block
`include "sd_gate_status_defines.svh"
`timescale 1ns/100ps
module test_sd_gate_status;
  // ----------
  // bench state, bus tasks and model
  // ----------
  localparam logic [3:0] ST = `OFS_IRQ_STAT;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk = 1'h0, rst_n = 1'h0, busyConds = 1'h0, dataActive = 1'h0, busClkOn = 1'h0, fourBitMode = 1'h0;
  logic irqPeriod = 1'h0, clkRun = 1'h0, conflict = 1'h0, irqReq = 1'h0, abortSeen = 1'h0;
  logic cardClk, cmdLine, irqN, cardClkEn_r, perClkEn_r, mstClkEn_r, ctlClkEn_r, cmdLineOe_r, cmdAbort_r, irq_r;
  sd_gate_status_pkg::reg_req_t regReq = '0;
  sd_gate_status_pkg::det_ev_t detEv = '0;
  logic [31:0] rdata_r, d, dmaFetchAddr = '0, mdlStat = '0, mdlEn = `STAT_EN_RST, mdlSig = '0;
  logic [7:0] acErrBits = '0;
  logic [3:0] nib, ex, got;
  logic [2:0] tok = '0;
  int edgeCnt, n_errors = 0, total_checks = 0, seed = 64;
  int bitOf[10] = '{3, 7, 9, 10, 11, 11, 12, 13, 14, 10};
  int posOf[13] = '{15, 14, 13, 12, 7, 6, 5, 4, 3, 8, 1, 2, 0};
  always #20 clk = ~clk;
  always @(posedge clk) if (cmdAbort_r) abortSeen <= 1'h1;
  sd_gate_status i_sd_gate_status (.clk(clk), .rst_n(rst_n), .regReq(regReq), .rdata_r(rdata_r), .detEv(detEv),
    .dmaFetchAddr(dmaFetchAddr), .acErrBits(acErrBits), .busyConds(busyConds), .dataActive(dataActive),
    .busClkOn(busClkOn), .fourBitMode(fourBitMode), .irqPeriod(irqPeriod), .card_clock_pin_in(cardClk),
    .card_command_line_in(cmdLine), .card_irq_n_in(irqN), .cardClkEn_r(cardClkEn_r), .perClkEn_r(perClkEn_r),
    .mstClkEn_r(mstClkEn_r), .ctlClkEn_r(ctlClkEn_r), .cmdLineOe_r(cmdLineOe_r), .cmdAbort_r(cmdAbort_r),
    .irq_r(irq_r));
  sd_card_model i_sd_card_model (.clkRun(clkRun), .conflict(conflict), .irqReq(irqReq), .cardClk(cardClk),
    .cmdLine(cmdLine), .irqN(irqN), .edgeCnt(edgeCnt));
  task summarize();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    regReq <= '{a, v, 1'h1, 1'h0};
    if (a == ST) mdlStat &= ~v;
    if (a == `OFS_STAT_EN) mdlEn = v & `STAT_MASK;
    if (a == `OFS_SIG_EN) mdlSig = v & `STAT_MASK;
    mdlStat &= mdlEn;
    @(posedge clk);
    regReq.wr <= 1'h0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clk);
    regReq <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge clk);
    regReq.rd <= 1'h0;
    #1 d = rdata_r;
  endtask : rd
  task rc(input logic [3:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, d);
    chk("irq", {31'h0, |(mdlStat & mdlSig)}, {31'h0, irq_r});
  endtask : rc
  task rs(input string nm);
    rc(ST, mdlStat, nm);
  endtask : rs
  task edges(input int n);
    int t;
    t = edgeCnt + n;
    for (int i = 0; i < 2000 && edgeCnt < t; i++) @(posedge clk);
    if (edgeCnt < t) begin
      n_errors++;
      summarize();
    end
  endtask : edges
  task ev(input int k);
    @(posedge clk);
    detEv <= 16'(1 << posOf[k]) | {4'h0, tok, 9'h0};
    if (k < 10 && (k < 9 || tok != `CRC_TOKEN_OK)) mdlStat[bitOf[k]] |= mdlEn[bitOf[k]];
    @(posedge clk);
    detEv <= '0;
  endtask : ev
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    rc(`OFS_STAT_EN, `STAT_EN_RST, "statEn");
    rc(`OFS_SYS_CTRL, `SYS_CTRL_RST, "sysCtrl");
    rc(`OFS_SIG_EN, 32'h0, "sigEn");
    rs("stat");
    rc(4'hF, 32'h0, "unmapped");
    for (int i = 0; i < 16; i++) begin
      nib = (i < 2) ? 4'(2 * i) : 4'($random(seed));
      {busyConds, busClkOn, dataActive} <= (i < 2) ? 3'h0 : 3'($random(seed));
      wr(`OFS_SYS_CTRL, {nib, 28'h0});
      repeat (4) @(posedge clk);
      #1 ex = {nib[3] | nib[1] | busyConds | busClkOn | dataActive, nib[2] | dataActive,
               nib[1] | busyConds | dataActive, nib[0]};
      got = {ctlClkEn_r, mstClkEn_r, perClkEn_r, cardClkEn_r} & {3'h7, ex[1]};
      chk("card_clock_on", {28'h0, ex & {3'h7, ex[1]}}, {28'h0, got});
    end
    {busyConds, busClkOn, dataActive} <= 3'h0;
    wr(`OFS_SIG_EN, ALL);
    for (int k = 0; k < 14; k++) begin
      tok = (k == 9) ? `CRC_TOKEN_OK : 3'($random(seed));
      dmaFetchAddr <= $random(seed);
      wr(ST, ALL);
      ev((k < 9) ? k : 9);
      rs("event");
      rs("sticky");
      if (k == 0) rc(`OFS_DMA_ADDR, dmaFetchAddr, "dmaAddr");
    end
    for (int k = 0; k < 9; k++) ev(k);
    wr(ST, 32'h00001208);
    rs("partClear");
    wr(`OFS_STAT_EN, `STAT_EN_RST & ~32'h00000208);
    ev(2);
    rs("masked");
    wr(`OFS_STAT_EN, `STAT_EN_RST);
    wr(`OFS_XFER_CTRL, 32'h1);
    rd(`OFS_XFER_CTRL);
    chk("doneWins", 32'h0, {31'h0, d[1]});
    wr(ST, ALL);
    acErrBits <= 8'($random(seed)) | 8'h1;
    repeat (3) @(posedge clk);
    mdlStat[`BIT_AC_ERR] = 1'h1;
    rc(`OFS_AC_ERR, {24'h0, acErrBits}, "acReg");
    rs("acFlag");
    acErrBits <= 8'h0;
    wr(`OFS_SIG_EN, 32'h0);
    rs("noIrq");
    wr(ST, ALL);
    wr(`OFS_SIG_EN, 32'h00800000);
    irqReq <= 1'h1;
    repeat (6) @(posedge clk);
    mdlStat[`BIT_CARD_IRQ_FLAG] = 1'h1;
    rs("cardIrq");
    wr(ST, 32'h00800000);
    mdlStat[`BIT_CARD_IRQ_FLAG] = 1'h1;
    rs("cardIrqAgain");
    wr(`OFS_SIG_EN, 32'h0);
    irqReq <= 1'h0;
    repeat (6) @(posedge clk);
    wr(ST, 32'h00800000);
    wr(`OFS_SIG_EN, 32'h00800000);
    rs("cardIrqGone");
    fourBitMode <= 1'h1;
    irqReq <= 1'h1;
    repeat (6) @(posedge clk);
    rs("outWindow");
    irqPeriod <= 1'h1;
    repeat (6) @(posedge clk);
    mdlStat[`BIT_CARD_IRQ_FLAG] = 1'h1;
    rs("inWindow");
    {irqReq, irqPeriod, fourBitMode} <= 3'h0;
    repeat (6) @(posedge clk);
    wr(ST, ALL);
    ev(10);
    clkRun <= 1'h1;
    edges(63);
    rs("before64");
    edges(2);
    repeat (4) @(posedge clk);
    mdlStat[`BIT_CTO] = 1'h1;
    rs("after64");
    wr(ST, ALL);
    ev(10);
    edges(10);
    ev(11);
    edges(70);
    rs("answered");
    clkRun <= 1'h0;
    conflict <= 1'h1;
    ev(12);
    clkRun <= 1'h1;
    edges(2);
    repeat (4) @(posedge clk);
    mdlStat |= 32'h0000C000;
    rs("conflict");
    chk("cmdOe", 32'h0, {31'h0, cmdLineOe_r});
    chk("abort", 32'h1, {31'h0, abortSeen});
    {clkRun, conflict} <= 2'h0;
    summarize();
  end
endmodule : test_sd_gate_status

// [verilog/sd_gate_status.sv]
// clock gating controls and interrupt status register of an sd card host
//
// Behaviour
// - card clock bit gates card clock pin
// - peripheral force-on keeps peripheral clock running
// - peripheral clock gated only when idle
// - master clock runs when forced on or during data transfer
// - controller clock gated only when idle
// - controller clock runs while peripheral clock runs
// - interrupt when flag and signal enable set
// - write one clears flag, zero keeps
// - card interrupt flag sets again after a clear while card asserts
// - dma error latches failing fetch address
// - auto stop error from register or skip
// - data end bit zero sets flag
// - data crc mismatch or bad token
// - busy or read timeout sets data timeout
// - response index mismatch sets flag
// - response end bit zero sets flag
// - response crc mismatch sets flag unless command timeout in same cycle
// - command line conflict aborts, sets two flags
// - no response in 64 clocks timeout
// - card interrupt mode dependent detection
// - cleared status enable clears and blocks flag
// - transfer complete beats data timeout
// - one shared interrupt line
`include "sd_gate_status_defines.svh"
`timescale 1ns/100ps
module sd_gate_status (
  input wire logic clk,
  input wire logic rst_n,
  input wire sd_gate_status_pkg::reg_req_t regReq,
  output logic [31:0] rdata_r,
  input wire sd_gate_status_pkg::det_ev_t detEv,
  input wire logic [31:0] dmaFetchAddr,
  input wire logic [7:0] acErrBits,
  input wire logic busyConds,
  input wire logic dataActive,
  input wire logic busClkOn,
  input wire logic fourBitMode,
  input wire logic irqPeriod,
  input wire logic card_clock_pin_in,
  input wire logic card_command_line_in,
  input wire logic card_irq_n_in,
  output logic cardClkEn_r,
  output logic perClkEn_r,
  output logic mstClkEn_r,
  output logic ctlClkEn_r,
  output logic cmdLineOe_r,
  output logic cmdAbort_r,
  output logic irq_r
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  logic clkPrev_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= 3'h6;
      syncB_r <= 3'h6;
    end else begin
      syncA_r <= {card_irq_n_in, card_command_line_in, card_clock_pin_in};
      syncB_r <= syncA_r;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev_r <= 1'b0;
    end else begin
      clkPrev_r <= syncB_r[0];
    end
  end
  logic linkEdge;
  assign linkEdge = syncB_r[0] & ~clkPrev_r;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] sysCtrl_r;
  logic [31:0] stat_r;
  logic [31:0] statEn_r;
  logic [31:0] sigEn_r;
  logic [31:0] dmaAddr_r;
  logic xferDone_r;
  logic wrSys, wrStat, wrStatEn, wrSigEn, wrXfer;
  assign wrSys = regReq.wr && regReq.addr == `OFS_SYS_CTRL;
  assign wrStat = regReq.wr && regReq.addr == `OFS_IRQ_STAT;
  assign wrStatEn = regReq.wr && regReq.addr == `OFS_STAT_EN;
  assign wrSigEn = regReq.wr && regReq.addr == `OFS_SIG_EN;
  assign wrXfer = regReq.wr && regReq.addr == `OFS_XFER_CTRL;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysCtrl_r <= `SYS_CTRL_RST;
    end else if (wrSys) begin
      sysCtrl_r <= regReq.wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statEn_r <= `STAT_EN_RST;
      sigEn_r <= 32'h00000000;
      xferDone_r <= 1'b0;
    end else begin
      if (wrStatEn) begin
        statEn_r <= regReq.wdata & `STAT_MASK;
      end
      if (wrSigEn) begin
        sigEn_r <= regReq.wdata & `STAT_MASK;
      end
      if (wrXfer) begin
        xferDone_r <= regReq.wdata[0];
      end
    end
  end
  // ----------------------------------------
  // command timeout and conflict monitor
  // ----------------------------------------
  sd_gate_status_pkg::cmd_st_t cmdSt_r;
  logic [6:0] toCnt_r;
  logic cmdTimeout;
  logic cmdConflict;
  logic driveHighPend_r;
  assign cmdTimeout = cmdSt_r == sd_gate_status_pkg::CMD_WAIT && linkEdge &&
                      toCnt_r == `CMD_TO_CYCLES - 7'h01 && !detEv.respStart;
  assign cmdConflict = driveHighPend_r && linkEdge && !syncB_r[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdSt_r <= sd_gate_status_pkg::CMD_IDLE;
      toCnt_r <= 7'h00;
    end else begin
      case (cmdSt_r)
        sd_gate_status_pkg::CMD_IDLE: begin
          toCnt_r <= 7'h00;
          if (detEv.cmdEnd) begin
            cmdSt_r <= sd_gate_status_pkg::CMD_WAIT;
          end
        end
        sd_gate_status_pkg::CMD_WAIT: begin
          if (detEv.respStart) begin
            cmdSt_r <= sd_gate_status_pkg::CMD_DONE;
          end else if (cmdTimeout) begin
            cmdSt_r <= sd_gate_status_pkg::CMD_DONE;
          end else if (linkEdge) begin
            toCnt_r <= toCnt_r + 7'h01;
          end
        end
        sd_gate_status_pkg::CMD_DONE: begin
          cmdSt_r <= sd_gate_status_pkg::CMD_IDLE;
        end
        default: begin
          cmdSt_r <= sd_gate_status_pkg::CMD_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      driveHighPend_r <= 1'b0;
      cmdLineOe_r <= 1'b0;
      cmdAbort_r <= 1'b0;
    end else begin
      cmdAbort_r <= cmdConflict;
      if (cmdConflict) begin
        driveHighPend_r <= 1'b0;
        cmdLineOe_r <= 1'b0;
      end else begin
        if (detEv.cmdDriveHigh) begin
          driveHighPend_r <= 1'b1;
        end else if (linkEdge) begin
          driveHighPend_r <= 1'b0;
        end
        cmdLineOe_r <= detEv.cmdDriveHigh | (cmdLineOe_r & ~detEv.cmdEnd);
      end
    end
  end
  // ----------------------------------------
  // card interrupt sampling
  // ----------------------------------------
  logic cardIrqSeen;
  assign cardIrqSeen = !syncB_r[2] && (!fourBitMode || irqPeriod);
  // ----------------------------------------
  // status flags
  // ----------------------------------------
  logic [31:0] setEv;
  always_comb begin
    setEv = 32'h00000000;
    setEv[`BIT_DMA_ERR] = detEv.dmaFail;
    setEv[`BIT_AC_ERR] = (|acErrBits) | detEv.acSkip;
    setEv[`BIT_DEND] = detEv.dEndZero;
    setEv[`BIT_DCRC] = detEv.dCrcBad |
                       (detEv.crcTokenValid && detEv.crcToken != `CRC_TOKEN_OK);
    setEv[`BIT_DTO] = detEv.busyTimeout | detEv.readTimeout;
    setEv[`BIT_CIDX] = detEv.idxBad;
    setEv[`BIT_CEND] = detEv.cEndZero;
    setEv[`BIT_CCRC] = (detEv.cCrcBad && !cmdTimeout) | cmdConflict;
    setEv[`BIT_CTO] = cmdTimeout | cmdConflict;
    setEv[`BIT_CARD_IRQ_FLAG] = cardIrqSeen;
  end
  logic [31:0] clrMask;
  assign clrMask = wrStat ? regReq.wdata : 32'h00000000;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= 32'h00000000;
    end else begin
      // set wins over clear; disabled flags forced to zero
      stat_r <= ((stat_r & ~clrMask) | setEv) & statEn_r & `STAT_MASK;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmaAddr_r <= 32'h00000000;
    end else if (detEv.dmaFail && statEn_r[`BIT_DMA_ERR]) begin
      dmaAddr_r <= dmaFetchAddr;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & sigEn_r);
    end
  end
  // ----------------------------------------
  // clock gating
  // ----------------------------------------
  logic [6:0] initCnt_r;
  logic initStart;
  assign initStart = wrSys && regReq.wdata[4] && initCnt_r == 7'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      initCnt_r <= 7'h00;
    end else if (initStart) begin
      initCnt_r <= `INIT_CLOCKS;
    end else if (initCnt_r != 7'h00 && linkEdge) begin
      initCnt_r <= initCnt_r - 7'h01;
    end
  end
  logic perNeed, ctlNeed;
  assign perNeed = sysCtrl_r[`BIT_PER_CLK] | busyConds | (initCnt_r != 7'h00) |
                   cardIrqSeen | dataActive;
  assign ctlNeed = sysCtrl_r[`BIT_CTL_CLK] | busyConds | cardIrqSeen | busClkOn | perNeed;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cardClkEn_r <= 1'b0;
      perClkEn_r <= 1'b0;
      mstClkEn_r <= 1'b0;
      ctlClkEn_r <= 1'b0;
    end else begin
      cardClkEn_r <= sysCtrl_r[`BIT_CARD_CLK] & perNeed;
      perClkEn_r <= perNeed;
      mstClkEn_r <= sysCtrl_r[`BIT_MST_CLK] | dataActive;
      ctlClkEn_r <= ctlNeed;
    end
  end
  // ----------------------------------------
  // read back
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
    end else if (regReq.rd) begin
      case (regReq.addr)
        `OFS_SYS_CTRL: rdata_r <= sysCtrl_r & 32'hF00000E0;
        `OFS_IRQ_STAT: rdata_r <= stat_r;
        `OFS_STAT_EN: rdata_r <= statEn_r;
        `OFS_SIG_EN: rdata_r <= sigEn_r;
        `OFS_DMA_ADDR: rdata_r <= dmaAddr_r;
        `OFS_AC_ERR: rdata_r <= {24'h000000, acErrBits};
        // transfer complete hides data timeout
        `OFS_XFER_CTRL: rdata_r <= {30'h00000000, ~xferDone_r & stat_r[`BIT_DTO], xferDone_r};
        default: rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_irq_follows_flags: assert property (@(posedge clk) disable iff (!rst_n)
    |(stat_r & sigEn_r) |=> irq_r) else $error("irq missing");
  a_w1c_clears: assert property (@(posedge clk) disable iff (!rst_n)
    wrStat && regReq.wdata[`BIT_CIDX] && !setEv[`BIT_CIDX] |=> !stat_r[`BIT_CIDX])
    else $error("w1c failed");
  a_sticky_flag: assert property (@(posedge clk) disable iff (!rst_n)
    stat_r[`BIT_CEND] && !wrStat && !wrStatEn |=> stat_r[`BIT_CEND]) else $error("flag lost");
  a_disabled_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !statEn_r[`BIT_DEND] |=> !stat_r[`BIT_DEND] || $past(wrStatEn)) else $error("masked flag set");
  a_conflict_flags: assert property (@(posedge clk) disable iff (!rst_n)
    cmdConflict && statEn_r[`BIT_CCRC] && statEn_r[`BIT_CTO] |=> stat_r[`BIT_CCRC] && stat_r[`BIT_CTO] &&
    !cmdLineOe_r) else $error("conflict not flagged");
  a_ctl_with_per: assert property (@(posedge clk) disable iff (!rst_n)
    perClkEn_r |-> ctlClkEn_r) else $error("ctl gated while per on");
  a_card_clk_off: assert property (@(posedge clk) disable iff (!rst_n)
    !sysCtrl_r[`BIT_CARD_CLK] |=> !cardClkEn_r) else $error("card clock on");
  a_timeout_count: assert property (@(posedge clk) disable iff (!rst_n)
    cmdTimeout |-> toCnt_r == 7'h3F) else $error("timeout count wrong");
  a_dma_addr: assert property (@(posedge clk) disable iff (!rst_n)
    detEv.dmaFail && statEn_r[`BIT_DMA_ERR] |=> dmaAddr_r == $past(dmaFetchAddr)) else $error("dma addr");
  a_card_irq_set: assert property (@(posedge clk) disable iff (!rst_n)
    cardIrqSeen && statEn_r[`BIT_CARD_IRQ_FLAG] |=> stat_r[`BIT_CARD_IRQ_FLAG])
    else $error("card irq flag not set");
  a_abort_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    cmdConflict |=> cmdAbort_r)
    else $error("abort missing");
  a_mst_forced: assert property (@(posedge clk) disable iff (!rst_n)
    sysCtrl_r[`BIT_MST_CLK] |=> mstClkEn_r)
    else $error("master clock gated while forced");
  a_mst_gated: assert property (@(posedge clk) disable iff (!rst_n)
    !sysCtrl_r[`BIT_MST_CLK] && !dataActive |=> !mstClkEn_r)
    else $error("master clock on while idle");
  a_per_forced: assert property (@(posedge clk) disable iff (!rst_n)
    sysCtrl_r[`BIT_PER_CLK] |=> perClkEn_r)
    else $error("peripheral clock gated while forced");
  a_token_bad: assert property (@(posedge clk) disable iff (!rst_n)
    detEv.crcTokenValid && detEv.crcToken != `CRC_TOKEN_OK && statEn_r[`BIT_DCRC] |=> stat_r[`BIT_DCRC])
    else $error("bad token not flagged");
  a_ac_level: assert property (@(posedge clk) disable iff (!rst_n)
    (|acErrBits) && statEn_r[`BIT_AC_ERR] |=> stat_r[`BIT_AC_ERR])
    else $error("auto stop error not flagged");
  a_dto_set: assert property (@(posedge clk) disable iff (!rst_n)
    (detEv.busyTimeout || detEv.readTimeout) && statEn_r[`BIT_DTO] |=> stat_r[`BIT_DTO])
    else $error("data timeout not flagged");
  a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !(|(stat_r & sigEn_r)) |=> !irq_r)
    else $error("irq without enabled flag");
  a_done_hides: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.rd && regReq.addr == `OFS_XFER_CTRL && xferDone_r |=> !rdata_r[1])
    else $error("timeout shown after completion");
  c_irq_again: cover property (@(posedge clk) disable iff (!rst_n)
    wrStat && regReq.wdata[`BIT_CARD_IRQ_FLAG] && cardIrqSeen);
  c_cmd_timeout: cover property (@(posedge clk) disable iff (!rst_n) cmdTimeout);
  c_conflict: cover property (@(posedge clk) disable iff (!rst_n) cmdConflict);
  c_card_irq: cover property (@(posedge clk) disable iff (!rst_n) stat_r[`BIT_CARD_IRQ_FLAG] && irq_r);
  c_init_run: cover property (@(posedge clk) disable iff (!rst_n) initStart ##1 initCnt_r == `INIT_CLOCKS);
endmodule : sd_gate_status

// [verilog/sd_gate_status_defines.svh]
// offsets, bit positions and timing counts for the sd clock gating and status block
`ifndef SD_GATE_STATUS_DEFINES_SVH
`define SD_GATE_STATUS_DEFINES_SVH
`define OFS_SYS_CTRL 4'h0
`define OFS_IRQ_STAT 4'h1
`define OFS_STAT_EN 4'h2
`define OFS_SIG_EN 4'h3
`define OFS_DMA_ADDR 4'h4
`define OFS_AC_ERR 4'h5
`define OFS_XFER_CTRL 4'h6
`define BIT_CARD_CLK 28
`define BIT_PER_CLK 29
`define BIT_MST_CLK 30
`define BIT_CTL_CLK 31
`define BIT_DMA_ERR 3
`define BIT_AC_ERR 7
`define BIT_DEND 9
`define BIT_DCRC 10
`define BIT_DTO 11
`define BIT_CIDX 12
`define BIT_CEND 13
`define BIT_CCRC 14
`define BIT_CTO 15
`define BIT_CARD_IRQ_FLAG 23
`define STAT_MASK 32'h0080FE88
`define SYS_CTRL_RST 32'h00000000
`define STAT_EN_RST 32'h0080FE88
`define CRC_TOKEN_OK 3'h2
`define CMD_TO_CYCLES 7'h40
`define INIT_CLOCKS 7'h50
`endif

// [verilog/sd_gate_status_pkg.sv]
// types for the sd clock gating and status block
package sd_gate_status_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic dmaFail;
    logic acSkip;
    logic dEndZero;
    logic dCrcBad;
    logic [2:0] crcToken;
    logic crcTokenValid;
    logic busyTimeout;
    logic readTimeout;
    logic idxBad;
    logic cEndZero;
    logic cCrcBad;
    logic respStart;
    logic cmdEnd;
    logic cmdDriveHigh;
  } det_ev_t;
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_WAIT = 2'b01,
    CMD_DONE = 2'b11
  } cmd_st_t;
endpackage : sd_gate_status_pkg
